// ===== design/pmmr_pkg.sv
// Package with register map, field layout and reset values of the monitor register bank
package pmmr_pkg;
   localparam logic [7:0]  CMD_ADC_CONFIG    = 8'hD0;
   localparam logic [7:0]  CMD_SHUNT_RESULT  = 8'hD1;
   localparam logic [7:0]  CMD_ALERT_MASK    = 8'hD2;
   localparam logic [7:0]  CMD_CALIBRATION   = 8'hD4;
   localparam logic [7:0]  CMD_DEV_CONFIG    = 8'hD5;
   localparam logic [7:0]  CMD_CLEAR_EIN     = 8'hD6;
   localparam logic [7:0]  CMD_CLEAR_FAULTS  = 8'h03;
   localparam logic [7:0]  CMD_STATUS_FLAGS  = 8'h80;
   localparam logic [7:0]  CMD_CURRENT       = 8'h8C;
   localparam logic [7:0]  CMD_POWER         = 8'h96;
   localparam logic [7:0]  CMD_ENERGY        = 8'h86;
   localparam logic [7:0]  CMD_SAMPLE_COUNT  = 8'h87;

   localparam logic [15:0] ADC_CONFIG_RST    = 16'h4127;
   localparam logic [15:0] ADC_CONFIG_WMASK  = 16'h0FFF;
   localparam logic [7:0]  ALERT_MASK_RST    = 8'hF0;
   localparam logic [15:0] CAL_RST           = 16'h0001;
   localparam logic [15:0] CAL_WMASK         = 16'h7FFF;
   localparam logic [7:0]  DEV_CONFIG_RST    = 8'h02;
   localparam logic [15:0] ZERO16            = 16'h0000;

   localparam int MODE_LSB   = 0;
   localparam int AVG_LSB    = 9;
   localparam int DC_STATUS  = 7;
   localparam int DC_ACC_LSB = 4;
   localparam int DC_FILT    = 3;
   localparam int DC_AUTOCLR = 2;
   localparam int DC_LATCH   = 1;
   localparam int DC_ALERT_POLARITY    = 0;
   localparam int SIGN_BIT   = 15;
   localparam int CAL_SHIFT  = 11;
   localparam int PWR_SHIFT  = 16;

   localparam logic [1:0]  ACC_POS_ONLY = 2'h1;
   localparam logic [1:0]  ACC_NEG_ONLY = 2'h2;
   localparam logic [1:0]  MODE_LOW_ZERO = 2'h0;

   typedef enum logic [1:0] {
      PMMR_IDLE = 2'b00,
      PMMR_RUN  = 2'b01,
      PMMR_HOLD = 2'b11
   } pmmr_conv_state_t;
endpackage

// ===== design/pmmr_conv_if.sv
// Interface between the register bank and the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
interface pmmr_conv_if;
   logic [2:0]  mode;
   logic [2:0]  avg_sel;
   logic        trigger;
   logic [15:0] shunt_result;
   logic [15:0] bus_result;
   logic        set_done;
   modport ctrl (input mode, input avg_sel, input trigger, output shunt_result, output bus_result, output set_done);
   modport regs (output mode, output avg_sel, output trigger, input shunt_result, input bus_result, input set_done);
endinterface
`default_nettype wire

// ===== design/pmmr_conv_ctrl.sv
// Conversion sequencer: operating mode decode, averaging and result holding
`timescale 1ns/1ps
`default_nettype none
module pmmr_conv_ctrl (
   input  wire logic          clk,
   input  wire logic          rstn,
   pmmr_conv_if.ctrl          cif,
   input  wire logic          adc_shunt_valid,
   input  wire logic [15:0]   adc_shunt_data,
   input  wire logic          adc_bus_valid,
   input  wire logic [15:0]   adc_bus_data,
   output logic               adc_shunt_en,
   output logic               adc_bus_en
);
   pmmr_pkg::pmmr_conv_state_t state_reg;
   logic [10:0]        cnt_reg;
   logic signed [26:0] shunt_sum_reg;
   logic signed [26:0] bus_sum_reg;
   logic [15:0]        shunt_result_reg;
   logic [15:0]        bus_result_reg;
   logic               set_done_reg;
   logic               want_shunt;
   logic               want_bus;
   logic               set_edge;
   logic               set_last;
   logic signed [26:0] shunt_add;

   function automatic logic is_shutdown(input logic [2:0] m);
      is_shutdown = (m[1:0] == pmmr_pkg::MODE_LOW_ZERO);
   endfunction

   function automatic logic [3:0] avg_shift(input logic [2:0] a);
      case (a)
         3'h0: avg_shift = 4'h0;
         3'h1: avg_shift = 4'h2;
         3'h2: avg_shift = 4'h4;
         3'h3: avg_shift = 4'h6;
         3'h4: avg_shift = 4'h7;
         3'h5: avg_shift = 4'h8;
         3'h6: avg_shift = 4'h9;
         default: avg_shift = 4'hA;
      endcase
   endfunction

   // Mode low bits select channels: bit0 shunt, bit1 bus
   assign want_shunt = cif.mode[0];
   assign want_bus   = cif.mode[1];
   // A set step completes on the last enabled channel of the pair
   assign set_edge = (state_reg == pmmr_pkg::PMMR_RUN) && (want_bus ? adc_bus_valid : adc_shunt_valid);
   assign set_last = (cnt_reg == 11'((12'h001 << avg_shift(cif.avg_sel)) - 12'h001));
   // Only a shunt sample present in this cycle joins the closing sum; a bus sample may close the set
   assign shunt_add = adc_shunt_valid ? 27'(signed'(adc_shunt_data)) : 27'h0;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= pmmr_pkg::PMMR_RUN;
      end else if (is_shutdown(cif.mode)) begin
         state_reg <= pmmr_pkg::PMMR_IDLE; // R3
      end else if (cif.mode[2]) begin
         state_reg <= pmmr_pkg::PMMR_RUN; // R1
      end else begin
         case (state_reg)
            pmmr_pkg::PMMR_RUN: begin
               if (cif.trigger) begin
                  state_reg <= pmmr_pkg::PMMR_RUN;
               end else if (set_edge && set_last) begin
                  state_reg <= pmmr_pkg::PMMR_HOLD; // R4
               end
            end
            default: begin
               if (cif.trigger) begin
                  state_reg <= pmmr_pkg::PMMR_RUN; // R2
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         adc_shunt_en <= 1'b0;
         adc_bus_en   <= 1'b0;
      end else begin
         adc_shunt_en <= (state_reg == pmmr_pkg::PMMR_RUN) && want_shunt && !is_shutdown(cif.mode); // R1 R2 R3
         adc_bus_en   <= (state_reg == pmmr_pkg::PMMR_RUN) && want_bus && !is_shutdown(cif.mode);
      end
   end

   // Averaging: sums restart with a new set or on a trigger write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg          <= '0;
         shunt_sum_reg    <= '0;
         bus_sum_reg      <= '0;
         shunt_result_reg <= pmmr_pkg::ZERO16;
         bus_result_reg   <= pmmr_pkg::ZERO16;
         set_done_reg     <= 1'b0;
      end else begin
         set_done_reg <= 1'b0;
         if (cif.trigger || state_reg != pmmr_pkg::PMMR_RUN) begin
            cnt_reg       <= '0;
            shunt_sum_reg <= '0;
            bus_sum_reg   <= '0;
         end else begin
            if (adc_shunt_valid && want_shunt) begin
               shunt_sum_reg <= shunt_sum_reg + 27'(signed'(adc_shunt_data));
            end
            if (adc_bus_valid && want_bus) begin
               bus_sum_reg <= bus_sum_reg + 27'(signed'(adc_bus_data));
            end
            if (set_edge) begin
               if (set_last) begin
                  cnt_reg       <= '0;
                  shunt_sum_reg <= '0;
                  bus_sum_reg   <= '0;
                  set_done_reg  <= 1'b1;
                  if (want_shunt) begin
                     shunt_result_reg <= 16'((shunt_sum_reg + shunt_add)
                                         >>> avg_shift(cif.avg_sel)); // R5 R6
                  end
                  if (want_bus) begin
                     bus_result_reg <= 16'((bus_sum_reg + 27'(signed'(adc_bus_data)))
                                       >>> avg_shift(cif.avg_sel));
                  end
               end else begin
                  cnt_reg <= cnt_reg + 11'h001;
               end
            end
         end
      end
   end

   assign cif.shunt_result = shunt_result_reg;
   assign cif.bus_result   = bus_result_reg;
   assign cif.set_done     = set_done_reg;
endmodule
`default_nettype wire

// ===== design/pmmr_top.sv
// Maker-specific register bank of the power monitor: commands, scaling, accumulator and alert
// Function
// R1: Mode 1xx nonzero low pair converts continuously
// R2: Mode 0xx nonzero low pair runs triggered conversions
// R3: Modes 000 and 100 power down
// R4: Triggered mode converts one set per write
// R5: Shunt result is 16-bit two's complement
// R6: Averaging enabled shows averaged shunt value
// R7: Shunt count is 2.5 uV, 7FFF full scale
// R8: Shunt read returns direct format only
// R9: Set mask bit blocks status bit from alert
// R10: Mask order: ready, overflow, POR, comm, warnings
// R11: Mask resets to F0
// R12: Calibration 15 bits, resets to one
// R13: Calibration scales current and power results
// R14: Device config byte resets to 02
// R15: Latch bit: zero transparent, one latched
// R16: Polarity bit inverts alert output
// R17: Auto-clear read clears accumulator and count
// R18: Accumulate mode 01 sums positive-current samples
`timescale 1ns/1ps
`default_nettype none
module pmmr_top (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic [7:0]    cmd_code,
   input  wire logic          cmd_wr,
   input  wire logic          cmd_rd,
   input  wire logic [15:0]   cmd_wdata,
   output logic [15:0]        cmd_rdata,
   output logic               cmd_rvalid,
   input  wire logic          adc_shunt_valid,
   input  wire logic [15:0]   adc_shunt_data,
   input  wire logic          adc_bus_valid,
   input  wire logic [15:0]   adc_bus_data,
   input  wire logic [7:0]    status_events,
   output logic               adc_shunt_en,
   output logic               adc_bus_en,
   output logic               input_filter_disable,
   output logic               alert_pin
);
   pmmr_conv_if cif ();

   logic [15:0]        adc_config_reg;
   logic [7:0]         alert_source_mask_reg;
   logic [15:0]        scale_calibration_reg;
   logic [7:0]         device_behaviour_config_reg;
   logic [7:0]         vendor_status_flags_reg;
   logic               trigger_reg;
   logic signed [15:0] current_result_reg;
   logic signed [15:0] power_result_reg;
   logic               power_valid_reg;
   logic [23:0]        energy_accum_reg;
   logic [23:0]        sample_count_reg;
   logic [7:0]         alert_src;
   logic               alert_active;
   logic               energy_read;
   logic               accum_clear;
   logic               accum_take;
   logic               mismatch;
   logic signed [31:0] cur_prod;
   logic signed [31:0] pwr_prod;

   function automatic logic wr_hit(input logic [7:0] code, input logic wr, input logic [7:0] target);
      wr_hit = wr && (code == target);
   endfunction

   pmmr_conv_ctrl u_conv (
      .clk             (clk),
      .rstn            (rstn),
      .cif             (cif.ctrl),
      .adc_shunt_valid (adc_shunt_valid),
      .adc_shunt_data  (adc_shunt_data),
      .adc_bus_valid   (adc_bus_valid),
      .adc_bus_data    (adc_bus_data),
      .adc_shunt_en    (adc_shunt_en),
      .adc_bus_en      (adc_bus_en)
   );

   assign cif.mode    = adc_config_reg[pmmr_pkg::MODE_LSB +: 3];
   assign cif.avg_sel = adc_config_reg[pmmr_pkg::AVG_LSB +: 3];
   assign cif.trigger = trigger_reg;

   // Configuration writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         adc_config_reg <= pmmr_pkg::ADC_CONFIG_RST; // R1
         trigger_reg    <= 1'b0;
      end else begin
         trigger_reg <= wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_ADC_CONFIG); // R4
         if (wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_ADC_CONFIG)) begin
            adc_config_reg <= (pmmr_pkg::ADC_CONFIG_RST & ~pmmr_pkg::ADC_CONFIG_WMASK)
                              | (cmd_wdata & pmmr_pkg::ADC_CONFIG_WMASK);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alert_source_mask_reg <= pmmr_pkg::ALERT_MASK_RST; // R11
      end else if (wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_ALERT_MASK)) begin
         alert_source_mask_reg <= cmd_wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scale_calibration_reg <= pmmr_pkg::CAL_RST; // R12
      end else if (wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_CALIBRATION)) begin
         scale_calibration_reg <= cmd_wdata & pmmr_pkg::CAL_WMASK; // R12
      end
   end

   // Sign-mismatch flag is set by hardware; a set wins over a host write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         device_behaviour_config_reg <= pmmr_pkg::DEV_CONFIG_RST; // R14
      end else begin
         if (wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_DEV_CONFIG)) begin
            device_behaviour_config_reg <= cmd_wdata[7:0];
         end
         if (mismatch) begin
            device_behaviour_config_reg[pmmr_pkg::DC_STATUS] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         input_filter_disable <= 1'b0;
      end else begin
         input_filter_disable <= device_behaviour_config_reg[pmmr_pkg::DC_FILT];
      end
   end

   // Scaling of current and power by the calibration value
   // Shunt result is signed: extend its sign so negative readings give negative current
   assign cur_prod = 32'(signed'(cif.shunt_result)) * 32'(signed'({1'b0, scale_calibration_reg[14:0]}));
   assign pwr_prod = 32'(current_result_reg) * 32'(signed'({1'b0, cif.bus_result[14:0]}));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         current_result_reg <= '0;
         power_result_reg   <= '0;
         power_valid_reg    <= 1'b0;
      end else begin
         power_valid_reg <= cif.set_done;
         current_result_reg <= 16'(cur_prod >>> pmmr_pkg::CAL_SHIFT); // R13
         if (cif.set_done) begin
            power_result_reg <= 16'(pwr_prod >>> pmmr_pkg::PWR_SHIFT); // R13
         end
      end
   end

   // Energy accumulator
   assign energy_read = cmd_rd && (cmd_code == pmmr_pkg::CMD_ENERGY);
   assign accum_clear = wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_CLEAR_EIN)
                        || (energy_read && device_behaviour_config_reg[pmmr_pkg::DC_AUTOCLR]); // R17
   assign accum_take  =
      (device_behaviour_config_reg[pmmr_pkg::DC_ACC_LSB +: 2] == pmmr_pkg::ACC_POS_ONLY) ?
         !current_result_reg[pmmr_pkg::SIGN_BIT] :
      (device_behaviour_config_reg[pmmr_pkg::DC_ACC_LSB +: 2] == pmmr_pkg::ACC_NEG_ONLY) ?
         current_result_reg[pmmr_pkg::SIGN_BIT] : 1'b1; // R18
   assign mismatch = power_valid_reg && !accum_take;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         energy_accum_reg <= '0;
         sample_count_reg <= '0;
      end else if (accum_clear) begin
         energy_accum_reg <= '0; // R17
         sample_count_reg <= '0;
      end else if (power_valid_reg) begin
         sample_count_reg <= sample_count_reg + 24'h000001; // R18
         if (accum_take) begin
            energy_accum_reg <= energy_accum_reg + 24'(power_result_reg); // R18
         end
      end
   end

   // Status flags and alert
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vendor_status_flags_reg <= '0;
      end else if (wr_hit(cmd_code, cmd_wr, pmmr_pkg::CMD_CLEAR_FAULTS)) begin
         vendor_status_flags_reg <= status_events | {cif.set_done, 7'h00};
      end else begin
         vendor_status_flags_reg <= vendor_status_flags_reg | status_events | {cif.set_done, 7'h00}; // R10
      end
   end

   assign alert_src = device_behaviour_config_reg[pmmr_pkg::DC_LATCH] ?
                      vendor_status_flags_reg : (status_events | {cif.set_done, 7'h00}); // R15
   assign alert_active = |(alert_src & ~alert_source_mask_reg); // R9

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alert_pin <= 1'b1;
      end else begin
         alert_pin <= !alert_active ^ device_behaviour_config_reg[pmmr_pkg::DC_ALERT_POLARITY]; // R16
      end
   end

   // Read data path: answer one cycle after the read strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_rdata  <= pmmr_pkg::ZERO16;
         cmd_rvalid <= 1'b0;
      end else begin
         cmd_rvalid <= cmd_rd;
         if (cmd_rd) begin
            case (cmd_code)
               pmmr_pkg::CMD_ADC_CONFIG:   cmd_rdata <= adc_config_reg;
               pmmr_pkg::CMD_SHUNT_RESULT: cmd_rdata <= cif.shunt_result; // R5 R7 R8
               pmmr_pkg::CMD_ALERT_MASK:   cmd_rdata <= {8'h00, alert_source_mask_reg};
               pmmr_pkg::CMD_CALIBRATION:  cmd_rdata <= scale_calibration_reg;
               pmmr_pkg::CMD_DEV_CONFIG:   cmd_rdata <= {8'h00, device_behaviour_config_reg};
               pmmr_pkg::CMD_STATUS_FLAGS: cmd_rdata <= {8'h00, vendor_status_flags_reg};
               pmmr_pkg::CMD_CURRENT:      cmd_rdata <= current_result_reg;
               pmmr_pkg::CMD_POWER:        cmd_rdata <= power_result_reg;
               pmmr_pkg::CMD_ENERGY:       cmd_rdata <= energy_accum_reg[15:0];
               pmmr_pkg::CMD_SAMPLE_COUNT: cmd_rdata <= sample_count_reg[15:0];
               default:                    cmd_rdata <= pmmr_pkg::ZERO16;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== verif/pmmr_checker.sv
// Port-level assertions of the monitor register bank
`timescale 1ns/1ps
`default_nettype none
module pmmr_checker (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  cmd_code,
   input wire logic        cmd_wr,
   input wire logic        cmd_rd,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata,
   input wire logic        cmd_rvalid,
   input wire logic        adc_shunt_en,
   input wire logic        adc_bus_en,
   input wire logic        input_filter_disable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic mode_wr;
   assign mode_wr = cmd_wr && cmd_code == pmmr_pkg::CMD_ADC_CONFIG;
   property p_ans; cmd_rd |=> cmd_rvalid; endproperty
   a_ans: assert property (p_ans) else $error("read answer missing");
   property p_quiet; !cmd_rd |=> !cmd_rvalid; endproperty
   a_quiet: assert property (p_quiet) else $error("read valid without read");
   property p_filt;
      cmd_wr && cmd_code == pmmr_pkg::CMD_DEV_CONFIG |-> ##2 input_filter_disable == $past(cmd_wdata[3], 2);
   endproperty
   a_filt: assert property (p_filt) else $error("filter pin not following config");
   property p_cal15; cmd_rd && cmd_code == pmmr_pkg::CMD_CALIBRATION |=> !cmd_rdata[15]; endproperty
   a_cal15: assert property (p_cal15) else $error("calibration top bit set");
   property p_hi;
      cmd_rd && (cmd_code == pmmr_pkg::CMD_ALERT_MASK || cmd_code == pmmr_pkg::CMD_DEV_CONFIG)
      |=> cmd_rdata[15:8] == 8'h00;
   endproperty
   a_hi: assert property (p_hi) else $error("byte register high byte not zero");
   property p_off; mode_wr && cmd_wdata[1:0] == 2'h0 |-> ##2 !adc_shunt_en && !adc_bus_en; endproperty
   a_off: assert property (p_off) else $error("converter enabled in power-down");
   property p_cont;
      mode_wr && cmd_wdata[2] && cmd_wdata[1:0] != 2'h0 |-> ##3
      adc_shunt_en == $past(cmd_wdata[0], 3) && adc_bus_en == $past(cmd_wdata[1], 3);
   endproperty
   a_cont: assert property (p_cont) else $error("continuous channels wrong");
   property p_trig;
      mode_wr && !cmd_wdata[2] && cmd_wdata[1:0] != 2'h0 |-> ##3
      adc_shunt_en == $past(cmd_wdata[0], 3) && adc_bus_en == $past(cmd_wdata[1], 3);
   endproperty
   a_trig: assert property (p_trig) else $error("triggered channels wrong");
endmodule
bind pmmr_top pmmr_checker chk_u (.clk, .rstn, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata,
   .cmd_rvalid, .adc_shunt_en, .adc_bus_en, .input_filter_disable);
`default_nettype wire

// ===== verif/pmmr_host_model.sv
// Host model issuing command-level register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pmmr_host_model (
   input  wire logic        clk,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_rvalid,
   output logic [7:0]       cmd_code,
   output logic             cmd_wr,
   output logic             cmd_rd,
   output logic [15:0]      cmd_wdata
);
   initial begin
      cmd_code = 8'h00;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_wdata = 16'h0000;
   end
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_code  <= c;
      cmd_wdata <= d;
      cmd_wr    <= 1'b1;
      @(posedge clk);
      cmd_wr    <= 1'b0;
      cmd_wdata <= ~d;
   endtask
   // Words are taken as raw direct-format counts
   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
      @(posedge clk);
      cmd_code <= c;
      cmd_rd   <= 1'b1;
      @(posedge clk);
      cmd_rd <= 1'b0;
      #1;
      ok = cmd_rvalid;
      d = cmd_rdata;
   endtask
endmodule
`default_nettype wire

// ===== verif/pmmr_top_bench.sv
// Self-checking bench of the monitor register bank
`timescale 1ns/1ps
`default_nettype none
module pmmr_top_bench;
   logic        clk, rstn, sv, bv, sh_en, bu_en, filt, alert, rvalid, wr, rd;
   logic [15:0] sd, bd, rdata, wdata;
   logic [7:0]  code, ev;
   int          fails, n_compared, cyc;
   always #5 clk = ~clk;
   pmmr_top dut_u (.clk(clk), .rstn(rstn), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd), .cmd_wdata(wdata),
      .cmd_rdata(rdata), .cmd_rvalid(rvalid), .adc_shunt_valid(sv), .adc_shunt_data(sd),
      .adc_bus_valid(bv), .adc_bus_data(bd), .status_events(ev), .adc_shunt_en(sh_en),
      .adc_bus_en(bu_en), .input_filter_disable(filt), .alert_pin(alert));
   pmmr_host_model host_u (.clk(clk), .cmd_rdata(rdata), .cmd_rvalid(rvalid), .cmd_code(code),
      .cmd_wr(wr), .cmd_rd(rd), .cmd_wdata(wdata));
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk16(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   task automatic rchk(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      host_u.rd(c, d, ok);
      chk1("rvalid", 1'b1, ok);
      chk16($sformatf("reg %h", c), e, d);
   endtask
   task automatic feed(input logic b, input logic [15:0] d);
      @(posedge clk);
      if (b) begin
         bv <= 1'b1;
         bd <= d;
      end else begin
         sv <= 1'b1;
         sd <= d;
      end
      @(posedge clk);
      sv <= 1'b0;
      bv <= 1'b0;
      sd <= ~d;
      bd <= ~d;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic set_ev(input logic [7:0] v);
      @(posedge clk);
      ev <= v;
   endtask
   task automatic t_reset();
      rchk(pmmr_pkg::CMD_ALERT_MASK, 16'h00F0);
      rchk(pmmr_pkg::CMD_CALIBRATION, 16'h0001);
      rchk(pmmr_pkg::CMD_DEV_CONFIG, 16'h0002);
      rchk(pmmr_pkg::CMD_SHUNT_RESULT, 16'h0000);
      rchk(8'hD3, 16'h0000);
      chk1("filter", 1'b0, filt);
      chk1("alert", 1'b1, alert);
      host_u.wr(pmmr_pkg::CMD_CALIBRATION, 16'hFFFF);
      rchk(pmmr_pkg::CMD_CALIBRATION, 16'h7FFF);
   endtask
   task automatic t_alert();
      host_u.wr(pmmr_pkg::CMD_DEV_CONFIG, 16'h0008);
      idle(3);
      chk1("filter", 1'b1, filt);
      for (int i = 0; i < 8; i++) begin
         set_ev(8'h01 << i);
         host_u.wr(pmmr_pkg::CMD_ALERT_MASK, {8'h00, ~(8'h01 << i)});
         idle(4);
         chk1("alert", 1'b0, alert);
         host_u.wr(pmmr_pkg::CMD_ALERT_MASK, {8'h00, 8'h01 << i});
         idle(4);
         chk1("alert", 1'b1, alert);
      end
      set_ev(8'h01);
      host_u.wr(pmmr_pkg::CMD_ALERT_MASK, 16'h0000);
      host_u.wr(pmmr_pkg::CMD_DEV_CONFIG, 16'h0001);
      idle(4);
      chk1("alert", 1'b1, alert);
      set_ev(8'h00);
      host_u.wr(pmmr_pkg::CMD_DEV_CONFIG, 16'h0002);
      host_u.wr(pmmr_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      idle(4);
      chk1("alert", 1'b1, alert);
      set_ev(8'h01);
      set_ev(8'h00);
      idle(4);
      chk1("alert", 1'b0, alert);
      host_u.wr(pmmr_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      idle(4);
      chk1("alert", 1'b1, alert);
      host_u.wr(pmmr_pkg::CMD_ALERT_MASK, 16'h00F0);
   endtask
   task automatic t_modes();
      logic [2:0] m;
      logic       on;
      for (int i = 0; i < 8; i++) begin
         m = i[2:0];
         on = m[1:0] != 2'h0;
         host_u.wr(pmmr_pkg::CMD_ADC_CONFIG, 16'h4120 | {13'h0000, m});
         idle(3);
         chk1("shunt_en", on & m[0], sh_en);
         chk1("bus_en", on & m[1], bu_en);
         if (on && !m[2]) begin
            if (m[0]) feed(1'b0, 16'h0010);
            if (m[1]) feed(1'b1, 16'h0020);
            idle(3);
            chk1("shunt_en", 1'b0, sh_en);
            chk1("bus_en", 1'b0, bu_en);
            if (m[0]) rchk(pmmr_pkg::CMD_SHUNT_RESULT, 16'h0010);
         end
      end
   endtask
   task automatic t_results();
      host_u.wr(pmmr_pkg::CMD_ADC_CONFIG, 16'h4325);
      idle(3);
      for (int i = 1; i < 5; i++) feed(1'b0, 16'h0000 - 16'(2 * i));
      idle(3);
      rchk(pmmr_pkg::CMD_SHUNT_RESULT, 16'hFFFB);
      rchk(pmmr_pkg::CMD_CURRENT, 16'hFFB0);
      host_u.wr(pmmr_pkg::CMD_CALIBRATION, 16'h0800);
      host_u.wr(pmmr_pkg::CMD_ADC_CONFIG, 16'h4121);
      idle(3);
      feed(1'b0, 16'h7FFF);
      idle(3);
      rchk(pmmr_pkg::CMD_SHUNT_RESULT, 16'h7FFF);
      rchk(pmmr_pkg::CMD_CURRENT, 16'h7FFF);
      host_u.wr(pmmr_pkg::CMD_CALIBRATION, 16'h0400);
      host_u.wr(pmmr_pkg::CMD_ADC_CONFIG, 16'h4121);
      idle(3);
      feed(1'b0, 16'h0100);
      idle(3);
      rchk(pmmr_pkg::CMD_CURRENT, 16'h0080);
   endtask
   task automatic t_energy();
      logic [15:0] d;
      logic        ok;
      rchk(pmmr_pkg::CMD_SAMPLE_COUNT, 16'h0006);
      host_u.wr(pmmr_pkg::CMD_DEV_CONFIG, 16'h0006);
      host_u.rd(pmmr_pkg::CMD_ENERGY, d, ok);
      chk1("energy rvalid", 1'b1, ok);
      rchk(pmmr_pkg::CMD_ENERGY, 16'h0000);
      rchk(pmmr_pkg::CMD_SAMPLE_COUNT, 16'h0000);
      host_u.wr(pmmr_pkg::CMD_DEV_CONFIG, 16'h0012);
      host_u.wr(pmmr_pkg::CMD_ADC_CONFIG, 16'h4121);
      idle(3);
      feed(1'b0, 16'hFFF0);
      idle(3);
      rchk(pmmr_pkg::CMD_DEV_CONFIG, 16'h0092);
      rchk(pmmr_pkg::CMD_SAMPLE_COUNT, 16'h0001);
      rchk(pmmr_pkg::CMD_ENERGY, 16'h0000);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      sv = 1'b0;
      bv = 1'b0;
      sd = 16'h0000;
      bd = 16'h0000;
      ev = 8'h00;
      fails = 0;
      n_compared = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_alert();
      t_modes();
      t_results();
      t_energy();
      close_out();
   end
endmodule
`default_nettype wire
